// ---- verilog/acd_params.svh ----
// timing counts, code limits and spans for the converter control block
`ifndef ACD_PARAMS_SVH
`define ACD_PARAMS_SVH
`define ACD_IN_BITS          12
`define ACD_CODE_BITS        8
`define ACD_CODE_MAX         8'hFF
`define ACD_CODE_MID         8'h80
`define ACD_CODE_MIN         8'h00
`define ACD_CAL_PATTERN_CYC  10
`define ACD_LAT_SECOND       7
`define ACD_LAT_FIRST        8
`define ACD_FRONT_STAGES     3
`define ACD_SPAN_LOW_MV      600
`define ACD_SPAN_HIGH_MV     800
`define ACD_SCALE_SHIFT      24
`define ACD_CNT_BITS         24
`define ACD_CAL_DELAY_SHORT  4096
`define ACD_CAL_DELAY_LONG   65536
`define ACD_CAL_RUN_CYC      1024
`endif

// ---- verilog/acd_pkg.sv ----
// types shared by the converter control block
package acd_pkg;
  typedef enum logic [1:0] {
    ACD_ST_POWERUP,
    ACD_ST_CALIBRATE,
    ACD_ST_IDLE
  } acd_cal_state_e;
  typedef logic [7:0] acd_code_t;
endpackage

// ---- verilog/acd_sync.sv ----
// two-flop level synchroniser, one bit per lane
`timescale 1ns/1ps
`default_nettype none
module acd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic [WIDTH-1:0] d_in,
  output var  logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_q;

  // no reset: the chain must pass reset itself through
  always_ff @(posedge clk_in) begin
    meta_q <= d_in;
    q_out  <= meta_q;
  end
endmodule
`default_nettype wire

// ---- verilog/acd_adc_ctrl.sv ----
// control, sampling pipeline and 1:2 output demultiplexer of the converter
`timescale 1ns/1ps
`default_nettype none
`include "acd_params.svh"

module acd_adc_ctrl
  import acd_pkg::*;
#(
  parameter int CAL_DELAY_SHORT = `ACD_CAL_DELAY_SHORT,
  parameter int CAL_DELAY_LONG  = `ACD_CAL_DELAY_LONG,
  parameter int CAL_RUN_CYC     = `ACD_CAL_RUN_CYC
) (
  input  wire logic                           clock_in,
  input  wire logic                           reset_in,
  input  wire logic                           sample_clk_in,
  input  wire logic signed [`ACD_IN_BITS-1:0] diff_mv_in,
  input  wire logic                           calibration_request_in,
  input  wire logic                           calibration_delay_select_in,
  input  wire logic                           power_down_request_in,
  input  wire logic                           range_select_in,
  input  wire logic                           output_edge_select_in,
  output var  acd_code_t                      first_sample_bus_out,
  output var  acd_code_t                      second_sample_bus_out,
  output var  logic                           out_of_range_out,
  output var  logic                           forwarded_output_clock_out,
  output var  logic                           calibration_active_out
);
  localparam int DEPTH = `ACD_LAT_SECOND - `ACD_FRONT_STAGES;
  localparam int SCALE_LO = ((1 << `ACD_SCALE_SHIFT) + `ACD_SPAN_LOW_MV - 1) / `ACD_SPAN_LOW_MV;
  localparam int SCALE_HI = ((1 << `ACD_SCALE_SHIFT) + `ACD_SPAN_HIGH_MV - 1)
                            / `ACD_SPAN_HIGH_MV;
  localparam logic signed [12:0] HALF_LO = 13'(`ACD_SPAN_LOW_MV / 2);
  localparam logic signed [12:0] HALF_HI = 13'(`ACD_SPAN_HIGH_MV / 2);
  localparam logic [3:0] PAT_CYC = 4'(`ACD_CAL_PATTERN_CYC);

  // sample clock domain
  logic [4:0] s_sync;
  logic       srst;
  logic       pd_s;
  logic       edge_s;
  logic       range_s;
  logic       cal_s;
  logic       cal_active_q;
  logic       run;

  acd_sync #(.WIDTH(5)) u_sync_sample (
    .clk_in (sample_clk_in),
    .d_in   ({reset_in, power_down_request_in, output_edge_select_in,
              range_select_in, cal_active_q}),
    .q_out  (s_sync)
  );
  assign {srst, pd_s, edge_s, range_s, cal_s} = s_sync;
  assign run = !pd_s && !cal_s;

  logic signed [`ACD_IN_BITS-1:0] samp1_q, samp1_d, samp2_q, samp2_d;
  logic [8:0]  conv_q, conv_d;
  logic [8:0]  pipe_q [DEPTH+1];
  logic [8:0]  pipe_d [DEPTH+1];
  logic        slot_q, slot_d;
  logic        tick_tgl_q, tick_tgl_d;
  acd_code_t   first_q, first_d, second_q, second_d;
  logic        oor_q, oor_d;
  logic        fwd_q, fwd_d;
  logic signed [12:0] half_mv;
  logic signed [12:0] off_mv;
  logic [14:0] scale;
  logic [24:0] prod;

  // conversion: offset binary, clamped at the span edges
  always_comb begin
    half_mv = range_s ? HALF_HI : HALF_LO;
    scale   = range_s ? 15'(SCALE_HI) : 15'(SCALE_LO);
    off_mv  = 13'(samp2_q) + half_mv;
    prod    = 25'(off_mv[9:0]) * 25'(scale);
    if (13'(samp2_q) >= half_mv) begin
      conv_d = {1'b1, `ACD_CODE_MAX};
    end else if (13'(samp2_q) < -half_mv) begin
      conv_d = {1'b1, `ACD_CODE_MIN};
    end else begin
      conv_d = {1'b0, prod[23:16]};
    end
    if (srst) begin
      conv_d = '0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi <= DEPTH; gi++) begin : g_pipe
      if (gi == 0) begin : g_head
        assign pipe_d[gi] = srst ? 9'h000 : conv_q;
      end else begin : g_body
        assign pipe_d[gi] = srst ? 9'h000 : pipe_q[gi-1];
      end
      always_ff @(negedge sample_clk_in) begin
        pipe_q[gi] <= pipe_d[gi];
      end
    end
  endgenerate

  always_comb begin
    samp1_d    = diff_mv_in;
    samp2_d    = samp1_q;
    slot_d     = ~slot_q;
    tick_tgl_d = ~tick_tgl_q;
    first_d    = first_q;
    second_d   = second_q;
    oor_d      = oor_q;
    fwd_d      = fwd_q;
    if (srst) begin
      slot_d     = 1'b0;
      tick_tgl_d = 1'b0;
      first_d    = `ACD_CODE_MIN;
      second_d   = `ACD_CODE_MIN;
      oor_d      = 1'b0;
      fwd_d      = 1'b0;
    end else if (!run) begin
      // quiet outputs in power down and while calibrating
      first_d  = `ACD_CODE_MIN;
      second_d = `ACD_CODE_MIN;
      oor_d    = 1'b0;
      fwd_d    = 1'b0;
    end else begin
      fwd_d = slot_q ? edge_s : ~edge_s;
      if (slot_q) begin
        first_d  = pipe_q[DEPTH][7:0];
        second_d = pipe_q[DEPTH-1][7:0];
        oor_d    = pipe_q[DEPTH][8] | pipe_q[DEPTH-1][8];
      end
    end
  end

  always_ff @(negedge sample_clk_in) begin
    samp1_q    <= samp1_d;
    samp2_q    <= samp2_d;
    conv_q     <= conv_d;
    slot_q     <= slot_d;
    tick_tgl_q <= tick_tgl_d;
    first_q    <= first_d;
    second_q   <= second_d;
    oor_q      <= oor_d;
    fwd_q      <= fwd_d;
  end

  assign first_sample_bus_out       = first_q;
  assign second_sample_bus_out      = second_q;
  assign out_of_range_out           = oor_q;
  assign forwarded_output_clock_out = fwd_q;

  // control clock domain
  logic [2:0] c_sync;
  logic       req_s;
  logic       dly_sel_s;
  logic       tick_s;
  logic       tick_prev_q, tick_prev_d;
  logic       tick;
  acd_cal_state_e state_q, state_d;
  logic [`ACD_CNT_BITS-1:0] cnt_q, cnt_d;
  logic [`ACD_CNT_BITS-1:0] delay_cyc;
  logic [3:0] low_cnt_q, low_cnt_d, high_cnt_q, high_cnt_d;
  logic       cal_active_d;

  acd_sync #(.WIDTH(3)) u_sync_ctrl (
    .clk_in (clock_in),
    .d_in   ({calibration_request_in, calibration_delay_select_in, tick_tgl_q}),
    .q_out  (c_sync)
  );
  assign {req_s, dly_sel_s, tick_s} = c_sync;
  // each sample edge arrives as a toggle, so counts are in sample cycles
  assign tick = tick_s ^ tick_prev_q;

  always_comb begin
    delay_cyc = dly_sel_s ? `ACD_CNT_BITS'(CAL_DELAY_LONG)
                          : `ACD_CNT_BITS'(CAL_DELAY_SHORT);
    tick_prev_d = tick_s;
    state_d     = state_q;
    cnt_d       = cnt_q;
    low_cnt_d   = low_cnt_q;
    high_cnt_d  = high_cnt_q;
    case (state_q)
      ACD_ST_POWERUP: begin
        if (tick) begin
          if (cnt_q + 1'b1 >= delay_cyc) begin
            state_d = ACD_ST_CALIBRATE;
            cnt_d   = '0;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
      end
      ACD_ST_CALIBRATE: begin
        // requests are not looked at here
        low_cnt_d  = '0;
        high_cnt_d = '0;
        if (tick) begin
          if (cnt_q + 1'b1 >= `ACD_CNT_BITS'(CAL_RUN_CYC)) begin
            state_d = ACD_ST_IDLE;
            cnt_d   = '0;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
      end
      ACD_ST_IDLE: begin
        if (tick) begin
          if (!req_s) begin
            high_cnt_d = '0;
            if (high_cnt_q != 4'h0) begin
              low_cnt_d = 4'h1;
            end else if (low_cnt_q < PAT_CYC) begin
              low_cnt_d = low_cnt_q + 4'h1;
            end
          end else if (low_cnt_q < PAT_CYC) begin
            low_cnt_d = '0;
          end else if (high_cnt_q + 4'h1 >= PAT_CYC) begin
            state_d    = ACD_ST_CALIBRATE;
            high_cnt_d = '0;
            low_cnt_d  = '0;
          end else begin
            high_cnt_d = high_cnt_q + 4'h1;
          end
        end
      end
      default: begin
        state_d = ACD_ST_POWERUP;
      end
    endcase
    if (reset_in) begin
      state_d     = ACD_ST_POWERUP;
      cnt_d       = '0;
      low_cnt_d   = '0;
      high_cnt_d  = '0;
      tick_prev_d = 1'b0;
    end
    cal_active_d = (state_d == ACD_ST_CALIBRATE);
  end

  always_ff @(posedge clock_in) begin
    tick_prev_q  <= tick_prev_d;
    state_q      <= state_d;
    cnt_q        <= cnt_d;
    low_cnt_q    <= low_cnt_d;
    high_cnt_q   <= high_cnt_d;
    cal_active_q <= cal_active_d;
  end

  assign calibration_active_out = cal_active_q;

  // checks
  // low half of the forwarded clock, then the update rise with edge select high
  sequence s_rise_pair;
    run && edge_s && !slot_q ##1 run && edge_s && slot_q;
  endsequence

  a_cal_pattern_start: assert property (@(posedge clock_in) disable iff (reset_in)
    (state_q == ACD_ST_IDLE && state_d == ACD_ST_CALIBRATE)
      |-> tick && req_s && low_cnt_q == PAT_CYC && high_cnt_q == PAT_CYC - 4'h1)
    else $error("calibration started without the full request pattern");
  a_low_restart: assert property (@(posedge clock_in) disable iff (reset_in)
    (state_q == ACD_ST_IDLE && tick && req_s && low_cnt_q < PAT_CYC) |=> low_cnt_q == 4'h0)
    else $error("early high did not restart the low count");
  a_cal_ignore_req: assert property (@(posedge clock_in) disable iff (reset_in)
    (state_q == ACD_ST_CALIBRATE && !tick)
      |=> state_q == ACD_ST_CALIBRATE && low_cnt_q == 4'h0 && high_cnt_q == 4'h0)
    else $error("request counted or calibration left without a sample tick");
  a_powerup_delay: assert property (@(posedge clock_in) disable iff (reset_in)
    (state_q == ACD_ST_POWERUP && state_d == ACD_ST_CALIBRATE)
      |-> tick && cnt_q + 1'b1 == delay_cyc)
    else $error("power-up delay ended at the wrong count");
  a_cal_flag_level: assert property (@(posedge clock_in) disable iff (reset_in)
    (state_d == ACD_ST_CALIBRATE) |=> calibration_active_out)
    else $error("calibration active not shown while calibrating");
  a_sample_edge: assert property (@(negedge sample_clk_in) disable iff (srst)
    $past(!srst, 2) |-> samp2_q == $past(diff_mv_in, 2))
    else $error("sample not taken on the falling edge");
  a_pair_order: assert property (@(negedge sample_clk_in) disable iff (srst)
    (run && slot_q) |=> first_sample_bus_out == $past(pipe_q[DEPTH][7:0])
                        && second_sample_bus_out == $past(pipe_q[DEPTH-1][7:0]))
    else $error("pair placed on the wrong buses");
  a_fwd_rise_edge: assert property (@(negedge sample_clk_in) disable iff (srst)
    s_rise_pair |=> fwd_q && !$past(fwd_q)
                    && first_sample_bus_out == $past(pipe_q[DEPTH][7:0]))
    else $error("forwarded clock not rising with the data");
  a_power_down_quiet: assert property (@(negedge sample_clk_in) disable iff (srst)
    pd_s |=> !forwarded_output_clock_out && first_sample_bus_out == `ACD_CODE_MIN)
    else $error("outputs active in power down");
  a_range_clamp: assert property (@(negedge sample_clk_in) disable iff (srst)
    (13'(samp2_q) >= half_mv) |=> conv_q == {1'b1, `ACD_CODE_MAX})
    else $error("over-range input not flagged");
  a_mid_code: assert property (@(negedge sample_clk_in) disable iff (srst)
    (samp2_q == '0) |=> conv_q == {1'b0, `ACD_CODE_MID})
    else $error("zero input not at midscale");
endmodule
`default_nettype wire

// ---- dv/acd_rx_model.sv ----
// receiving logic model that latches both output buses on the forwarded clock
`timescale 1ns/1ps
`default_nettype none
module acd_rx_model
  import acd_pkg::*;
(
  input  wire logic      fwd_clk_in,
  input  wire logic      edge_select_in,
  input  wire acd_code_t first_in,
  input  wire acd_code_t second_in,
  output var  acd_code_t first_seen_out,
  output var  acd_code_t second_seen_out
);
  // data moves on one forwarded edge, so latch on the other where it is settled
  always @(fwd_clk_in) begin
    if (fwd_clk_in !== edge_select_in) begin
      first_seen_out  <= first_in;
      second_seen_out <= second_in;
    end
  end
endmodule
`default_nettype wire

// ---- dv/adc_control_and_demux_output_tb.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_control_and_demux_output_tb
  import acd_pkg::*;
;
  localparam int DLY_S = 16;
  localparam int DLY_L = 32;
  localparam int RUN   = 40;
  logic               clock_in = 1'b0, sample_clk = 1'b0, reset_in = 1'b1;
  logic signed [11:0] diff_mv = '0;
  logic               req = 1'b1, dly_sel = 1'b0, pd = 1'b0, rs = 1'b0, oes = 1'b0;
  acd_code_t          first_bus, second_bus, rx_first, rx_second;
  logic               oor, fwd, cal;
  int                 err_count = 0, total_checks = 0, seed = 32'h4594;
  int                 skip = 20, n = 0, r, h, v, hist_v [16];
  logic               hist_r [16];
  logic               fwd_prev = 1'b0, have_prev = 1'b0, cal_seen = 1'b0;
  logic [8:0]         e1, e2, p1, p2;

  always #5 clock_in = ~clock_in;
  // odd offset keeps link edges away from control clock edges
  initial begin
    #3.3;
    forever #80 sample_clk = ~sample_clk;
  end

  acd_adc_ctrl #(.CAL_DELAY_SHORT(DLY_S), .CAL_DELAY_LONG(DLY_L), .CAL_RUN_CYC(RUN))
    acd_adc_ctrl_inst (.clock_in(clock_in), .reset_in(reset_in), .sample_clk_in(sample_clk),
    .diff_mv_in(diff_mv), .calibration_request_in(req), .calibration_delay_select_in(dly_sel),
    .power_down_request_in(pd), .range_select_in(rs), .output_edge_select_in(oes),
    .first_sample_bus_out(first_bus), .second_sample_bus_out(second_bus),
    .out_of_range_out(oor), .forwarded_output_clock_out(fwd), .calibration_active_out(cal));

  acd_rx_model acd_rx_model_inst (.fwd_clk_in(fwd), .edge_select_in(oes), .first_in(first_bus),
    .second_in(second_bus), .first_seen_out(rx_first), .second_seen_out(rx_second));

  function automatic logic [8:0] code_of(input int x, input logic sel);
    int hh, k;
    hh = sel ? 400 : 300;
    k = ((1 << 24) + 2 * hh - 1) / (2 * hh);
    if (x >= hh) return {1'b1, 8'hFF};
    if (x < -hh) return {1'b1, 8'h00};
    return {1'b0, 8'(((x + hh) * k) >>> 16)};
  endfunction

  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_in(input string name, input int lo, input int hi, input int got);
    total_checks++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic ticks(input int k);
    repeat (k) @(negedge sample_clk);
    @(negedge clock_in);
  endtask

  task automatic req_pat(input int lo, input int hi);
    req = 1'b0;
    ticks(lo);
    req = 1'b1;
    ticks(hi);
  endtask

  task automatic power_up(input logic sel, input int dly);
    int t;
    t = 0;
    reset_in = 1'b1;
    dly_sel = sel;
    // held past four link periods so the link side sees the reset as well
    repeat (70) @(negedge clock_in);
    reset_in = 1'b0;
    while (cal !== 1'b1 && t < 200) begin
      @(negedge sample_clk);
      t++;
    end
    chk_in("powerup delay", dly - 1, dly + 6, t);
    t = 0;
    while (cal === 1'b1 && t < 200) begin
      @(negedge sample_clk);
      #1;
      t++;
      if (t == 6) chk("quiet in cal", 9'h000, {fwd | oor, first_bus | second_bus});
    end
    chk_in("cal length", RUN - 1, RUN + 4, t);
    @(negedge clock_in);
  endtask

  always @(posedge cal) cal_seen = 1'b1;

  always @(posedge sample_clk) begin
    @(negedge clock_in);
    r = $random(seed);
    h = rs ? 400 : 300;
    case (r[2:0])
      3'h0: v = h;
      3'h1: v = -h;
      3'h2: v = -h - 1;
      3'h3: v = 0;
      3'h4: v = h - 1;
      default: v = r % 450;
    endcase
    diff_mv <= 12'(v);
  end

  always @(negedge sample_clk) begin
    n++;
    hist_v[n % 16] = int'(diff_mv);
    hist_r[n % 16] = rs;
    #1;
    if (cal !== 1'b0 || pd || reset_in) skip = 12;
    if (skip > 0) begin
      skip--;
      have_prev = 1'b0;
    end else if (fwd !== fwd_prev && fwd === oes) begin
      e2 = code_of(hist_v[(n - 7) % 16], hist_r[(n - 7) % 16]);
      e1 = code_of(hist_v[(n - 8) % 16], hist_r[(n - 8) % 16]);
      chk("second bus", {1'b0, e2[7:0]}, {1'b0, second_bus});
      chk("first bus", {1'b0, e1[7:0]}, {1'b0, first_bus});
      chk("out of range", {8'h00, e1[8] | e2[8]}, {8'h00, oor});
      if (have_prev) chk("rx first", p1, {1'b0, rx_first});
      if (have_prev) chk("rx second", p2, {1'b0, rx_second});
      p1 = {1'b0, e1[7:0]};
      p2 = {1'b0, e2[7:0]};
      have_prev = 1'b1;
    end
    fwd_prev = fwd;
  end

  initial begin
    #500000;
    err_count++;
    give_verdict();
  end

  initial begin
    power_up(1'b0, DLY_S);
    for (int i = 0; i < 4; i++) begin
      rs = i[0];
      oes = i[1];
      skip = 12;
      ticks(60);
    end
    pd = 1'b1;
    ticks(6);
    repeat (4) begin
      chk("power down quiet", 9'h000, {fwd | oor, first_bus | second_bus});
      ticks(1);
    end
    pd = 1'b0;
    ticks(40);
    cal_seen = 1'b0;
    req_pat(9, 14);
    ticks(4);
    chk("cal after short low", 9'h000, {8'h00, cal_seen});
    req_pat(10, 10);
    ticks(4);
    chk("cal after pattern", 9'h001, {8'h00, cal_seen});
    // a full pattern while calibrating must leave no pending request
    req_pat(11, 11);
    repeat (40) if (cal === 1'b1) ticks(1);
    cal_seen = 1'b0;
    ticks(14);
    chk("request during cal", 9'h000, {8'h00, cal_seen});
    power_up(1'b1, DLY_L);
    give_verdict();
  end
endmodule
`default_nettype wire
